// File: logic/pfs_pad_route.v
`timescale 1ns/10ps
`default_nettype none
// Routes one pad to GPIO or to one of up to eight peripheral slots.
module pfs_pad_route (
	// Selection.
	input wire periph_en,
	input wire [2:0] func_code,
	// Sources.
	input wire gpio_out,
	input wire gpio_oe,
	input wire [7:0] periph_out,
	input wire [7:0] periph_oe,
	// Pad side.
	output wire pad_out,
	output wire pad_oe
);
	// Exactly one source drives the pad at a time.
	assign pad_out = periph_en ? periph_out[func_code] : gpio_out;
	assign pad_oe = periph_en ? periph_oe[func_code] : gpio_oe;
endmodule // pfs_pad_route
`default_nettype wire

// File: logic/pfs_port0_mux.v
// Behaviour
// R1: function-select bit 0 routes pad to GPIO, 1 to peripheral.
// R2: bits 0 to 5 take peripheral choice from select register zero upper fields.
// R3: bits 6 to 22 except 18 use select register one fields.
// R4: bits 23 to 31 use select register two fields 1:0 to 17:16.
// R5: after reset all multiplexed pads are GPIO; dedicated I2C pads excluded.
// R6: each pad offers eight peripheral slots plus GPIO; here only pads 10 and 13 reach all eight, the others four or two, pad 18 one.
// R7: pull-ups marked on are enabled from reset, software changeable.
// R8: pull-ups marked off reset disabled; dash pads have no control.
// R9: debug handshake pad has a pull-down enabled from reset.
// R10: straps must be driven to defined levels during reset.
// R11: write the mask register immediately before each select register write.
// R12: routing changes only after the write completes, never two functions at once.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_consts.vh"
module pfs_port0_mux #(
	parameter PULL_ON_MASK = 32'hFFFFFFFF,
	parameter PULL_HAS_CTRL = 32'hFFFFFFFF
) (
	// Clock and reset.
	input wire hclk,
	input wire hresetn,
	input wire clk_en,
	// AHB-Lite slave.
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Straps sampled at reset release.
	input wire [3:0] boot_strap_inputs,
	input wire [1:0] test_strap_inputs,
	// GPIO and peripheral sources.
	input wire [31:0] gpio_out,
	input wire [31:0] gpio_oe,
	input wire [255:0] periph_out,
	input wire [255:0] periph_oe,
	// Pads.
	output wire [31:0] pad_out,
	output wire [31:0] pad_oe,
	output wire [31:0] pad_pull_en,
	output reg dbg_ack_pulldown_en
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [31:0] port0_func_sel_bits;
	reg [31:0] periph_select_reg_zero;
	reg [31:0] periph_select_reg_one;
	reg [31:0] periph_select_reg_two;
	reg [31:0] pullup_control_regs;
	// Strap levels caught once after reset.
	reg [5:0] strap_latch;
	reg strap_taken;
	// Lock state of the select registers.
	reg unlocked;
	reg lock_error;
	// Write flag and address of the transfer now in its data phase.
	reg dp_write;
	reg [7:0] dp_addr;
	wire addr_phase;
	wire psel_hit;

	// ------------------------------------------------------------
	// Bus interface
	// ------------------------------------------------------------
	// Every transfer completes with no wait state and an OKAY answer.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// A transfer is taken when selected, ready and NONSEQ or SEQ.
	assign addr_phase = hsel & hready & htrans[1];
	// The three select registers share the write-mask lock.
	assign psel_hit = (dp_addr == `PFS_OFS_PSEL0) | (dp_addr == `PFS_OFS_PSEL1) |
		(dp_addr == `PFS_OFS_PSEL2);

	// Address phase capture and register writes in the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			port0_func_sel_bits <= `PFS_RST_FUNC_SEL; // R5
			periph_select_reg_zero <= `PFS_RST_PSEL;
			periph_select_reg_one <= `PFS_RST_PSEL;
			periph_select_reg_two <= `PFS_RST_PSEL;
			pullup_control_regs <= `PFS_RST_PULL;
			unlocked <= 1'b0;
			lock_error <= 1'b0;
			dbg_ack_pulldown_en <= 1'b1; // R9
		end else if (clk_en) begin
			dp_write <= addr_phase & hwrite;
			dp_addr <= addr_phase ? haddr : dp_addr;
			if (dp_write) begin
				// Any write other than the mask write clears the unlock.
				unlocked <= (dp_addr == `PFS_OFS_WMASK) &&
					(hwdata == ~`PFS_UNLOCK_KEY); // R11
				if (psel_hit && !unlocked)
					lock_error <= 1'b1; // R11
				// Register writes land at the end of the data phase.
				// Status bit 0 is cleared by writing a one to it.
				case (dp_addr)
				`PFS_OFS_FUNC_SEL: port0_func_sel_bits <= hwdata; // R12
				`PFS_OFS_PSEL0: if (unlocked) periph_select_reg_zero <= hwdata;
				`PFS_OFS_PSEL1: if (unlocked) periph_select_reg_one <= hwdata;
				`PFS_OFS_PSEL2: if (unlocked) periph_select_reg_two <= hwdata;
				`PFS_OFS_PULL: pullup_control_regs <= hwdata ^ PULL_ON_MASK; // R7 R8
				`PFS_OFS_STATUS: if (hwdata[0]) lock_error <= 1'b0;
				default: dbg_ack_pulldown_en <= dbg_ack_pulldown_en;
				endcase
				if (dp_addr == `PFS_OFS_STRAP)
					dbg_ack_pulldown_en <= hwdata[31]; // R9
			end
		end
	end

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// Straps are caught on the first enabled edge after reset release.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_latch <= 6'h00;
			strap_taken <= 1'b0;
		end else if (clk_en && !strap_taken) begin
			strap_latch <= {test_strap_inputs, boot_strap_inputs}; // R10
			strap_taken <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Read-back
	// ------------------------------------------------------------
	// Read data, registered at the end of the address phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (clk_en && addr_phase && !hwrite) begin
			case (haddr)
			`PFS_OFS_FUNC_SEL: hrdata <= port0_func_sel_bits;
			`PFS_OFS_PSEL0: hrdata <= periph_select_reg_zero;
			`PFS_OFS_PSEL1: hrdata <= periph_select_reg_one;
			`PFS_OFS_PSEL2: hrdata <= periph_select_reg_two;
			`PFS_OFS_PULL: hrdata <= pad_pull_en; // R7 R8
			`PFS_OFS_STRAP: hrdata <= {dbg_ack_pulldown_en, 25'h0000000, strap_latch};
			`PFS_OFS_STATUS: hrdata <= {30'h00000000, unlocked, lock_error};
			default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pad routing
	// ------------------------------------------------------------
	// Pull enables: stored XORed with PULL_ON_MASK so reset gives the marked default.
	assign pad_pull_en = (pullup_control_regs ^ PULL_ON_MASK) & PULL_HAS_CTRL; // R7 R8

	// Each pad except 18 picks its slot code from a fixed field of one select register.
	// The field is chosen at elaboration, so no pad indexes outside its register.
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_pad
			wire [2:0] code;
			if (i == 0) begin : g_code
				// Two-bit field in the upper half of select register zero.
				assign code = {1'b0, periph_select_reg_zero[23:22]}; // R2
			end else if (i == 1) begin : g_code
				// One-bit fields reach slot 0 or 1 only.
				assign code = {2'b00, periph_select_reg_zero[`PFS_PAD1_SEL_BIT]}; // R2
			end else if (i == 2) begin : g_code
				assign code = {2'b00, periph_select_reg_zero[`PFS_PAD2_SEL_BIT]}; // R2
			end else if (i < 6) begin : g_code
				assign code = {1'b0, periph_select_reg_zero[2*i+20 +: 2]}; // R2
			end else if (i < 10) begin : g_code
				// Select register one fills from its bottom bit upwards.
				assign code = {1'b0, periph_select_reg_one[2*i-12 +: 2]}; // R3
			end else if (i == 10) begin : g_code
				// A three-bit field reaches all eight slots.
				assign code = periph_select_reg_one[10:8]; // R3 R6
			end else if (i == 11) begin : g_code
				assign code = {1'b0, periph_select_reg_one[12:11]}; // R3
			end else if (i == 12) begin : g_code
				assign code = {1'b0, periph_select_reg_one[14:13]}; // R3
			end else if (i == 13) begin : g_code
				// The second three-bit field.
				assign code = periph_select_reg_one[17:15]; // R3 R6
			end else if (i < 17) begin : g_code
				assign code = {1'b0, periph_select_reg_one[2*i-10 +: 2]}; // R3
			end else if (i == 17) begin : g_code
				// One-bit fields again, with a gap for the fixed pad.
				assign code = {2'b00, periph_select_reg_one[`PFS_PAD17_SEL_BIT]}; // R3
			end else if (i == 18) begin : g_code
				// This pad has one peripheral function and no select field.
				assign code = `PFS_FIXED_FUNC; // R3
			end else if (i == 19) begin : g_code
				assign code = {2'b00, periph_select_reg_one[`PFS_PAD19_SEL_BIT]}; // R3
			end else if (i == 20) begin : g_code
				assign code = {2'b00, periph_select_reg_one[`PFS_PAD20_SEL_BIT]}; // R3
			end else if (i < 23) begin : g_code
				assign code = {1'b0, periph_select_reg_one[2*i-14 +: 2]}; // R3
			end else begin : g_code
				// Select register two, from its bottom bit upwards.
				assign code = {1'b0, periph_select_reg_two[2*i-46 +: 2]}; // R4
			end
			// The route cell switches the pad between GPIO and the chosen slot.
			pfs_pad_route u_route (
				.periph_en(port0_func_sel_bits[i]), // R1 R12
				.func_code(code), // R6
				.gpio_out(gpio_out[i]),
				.gpio_oe(gpio_oe[i]),
				.periph_out(periph_out[8*i +: 8]),
				.periph_oe(periph_oe[8*i +: 8]),
				.pad_out(pad_out[i]),
				.pad_oe(pad_oe[i])
			);
		end
	endgenerate
endmodule // pfs_port0_mux
`default_nettype wire

// File: pkg/pfs_consts.vh
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH
// Register byte offsets on the bus.
`define PFS_OFS_FUNC_SEL 8'h00
`define PFS_OFS_PSEL0 8'h04
`define PFS_OFS_PSEL1 8'h08
`define PFS_OFS_PSEL2 8'h0C
`define PFS_OFS_WMASK 8'h10
`define PFS_OFS_PULL 8'h14
`define PFS_OFS_STRAP 8'h18
`define PFS_OFS_STATUS 8'h1C
// Reset values.
`define PFS_RST_FUNC_SEL 32'h00000000
`define PFS_RST_PSEL 32'h00000000
`define PFS_RST_PULL 32'h00000000
// Unlock key; the mask register takes the inverse of the value that follows.
`define PFS_UNLOCK_KEY 32'hA5A5A5A5
// Field positions of the one-bit select fields.
`define PFS_PAD1_SEL_BIT 24
`define PFS_PAD2_SEL_BIT 25
`define PFS_PAD17_SEL_BIT 24
`define PFS_PAD19_SEL_BIT 26
`define PFS_PAD20_SEL_BIT 27
// Fixed function code used by the pad that has no select field.
`define PFS_FIXED_FUNC 3'h0
`endif

// File: testbench/pfs_port0_checker.sv
`timescale 1ns/10ps
`default_nettype none
// Checks pad routing and pad defaults at the ports.
module pfs_chk #(parameter PULL_ON_MASK = 32'hFFFFFFFF, parameter PULL_HAS_CTRL = 32'hFFFFFFFF) (
	// Bus.
	input wire hclk, input wire hresetn, input wire clk_en, input wire hsel,
	input wire [7:0] haddr, input wire [1:0] htrans, input wire hwrite, input wire hready,
	input wire [31:0] hwdata, input wire hreadyout, input wire hresp,
	// Sources and pads.
	input wire [31:0] gpio_out, input wire [31:0] gpio_oe, input wire [255:0] periph_out,
	input wire [255:0] periph_oe, input wire [31:0] pad_out, input wire [31:0] pad_oe,
	input wire [31:0] pad_pull_en, input wire dbg_ack_pulldown_en
);
	reg wph, wph2, wfs;
	reg [31:0] fs;
	// Shadows the select word, which lands one edge after its address phase.
	// A low clock enable freezes the shadow just as it freezes the design.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph <= 1'b0;
			wph2 <= 1'b0;
			wfs <= 1'b0;
			fs <= 32'h00000000;
		end else if (clk_en) begin
			wph <= hsel && hready && htrans[1] && hwrite;
			wph2 <= wph;
			wfs <= hsel && hready && htrans[1] && hwrite && haddr == 8'h00;
			if (wfs) fs <= hwdata;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// No write has just landed, reset has not just fallen and no source moved.
	sequence s_quiet;
		hresetn && !wph2 && $stable(gpio_out) && $stable(gpio_oe) &&
		$stable(periph_out) && $stable(periph_oe);
	endsequence
	property p_ok; hreadyout && !hresp; endproperty
	property p_gpio; (pad_out & ~fs) == (gpio_out & ~fs) && (pad_oe & ~fs) == (gpio_oe & ~fs); endproperty
	property p_fix; fs[18] |-> pad_out[18] == periph_out[144] && pad_oe[18] == periph_oe[144]; endproperty
	property p_rgpio; $rose(hresetn) |-> pad_out == gpio_out; endproperty
	property p_rpull; $rose(hresetn) |-> pad_pull_en == (PULL_ON_MASK & PULL_HAS_CTRL); endproperty
	property p_nopull; (pad_pull_en & ~PULL_HAS_CTRL) == 32'h00000000; endproperty
	property p_rdown; $rose(hresetn) |-> dbg_ack_pulldown_en; endproperty
	property p_hold; s_quiet |-> $stable(pad_out) && $stable(pad_oe); endproperty
	a_ok: assert property (p_ok) else $error("bus answer wrong");
	a_gpio: assert property (p_gpio) else $error("gpio path wrong");
	a_fix: assert property (p_fix) else $error("fixed pad wrong");
	a_rgpio: assert property (p_rgpio) else $error("pads not gpio at reset");
	a_rpull: assert property (p_rpull) else $error("pull reset wrong");
	a_nopull: assert property (p_nopull) else $error("pull without control");
	a_rdown: assert property (p_rdown) else $error("pulldown reset wrong");
	a_hold: assert property (p_hold) else $error("pads moved unasked");
endmodule // pfs_chk
bind pfs_port0_mux pfs_chk #(.PULL_ON_MASK(PULL_ON_MASK), .PULL_HAS_CTRL(PULL_HAS_CTRL)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_out(gpio_out),
	.gpio_oe(gpio_oe), .periph_out(periph_out), .periph_oe(periph_oe), .pad_out(pad_out),
	.pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .dbg_ack_pulldown_en(dbg_ack_pulldown_en));
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pfs_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
	localparam logic [31:0] PON = 32'h0F0FFFFF;
	localparam logic [31:0] PHC = 32'hFFFF00FF;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ce = 1;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 0, go = 0, ge = 0, fs, p0, p1, p2, rd, seed = 32'd14317;
	logic [255:0] po = 0, pe = 0;
	wire hreadyout, hresp, dbg;
	wire [31:0] hrdata, pad_out, pad_oe, pad_pull_en;
	int failures = 0, check_count = 0;
	int lt[23] = '{22,24,25,26,28,30,0,2,4,6,8,11,13,15,18,20,22,24,0,26,27,28,30};
	int wt[23] = '{2,1,1,2,2,2,2,2,2,2,3,2,2,3,2,2,2,1,0,1,1,2,2};
	pfs_port0_mux #(.PULL_ON_MASK(PON), .PULL_HAS_CTRL(PHC)) DUT (.hclk(hclk), .hresetn(hresetn),
		.clk_en(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.boot_strap_inputs(4'h9), .test_strap_inputs(2'h2), .gpio_out(go), .gpio_oe(ge),
		.periph_out(po), .periph_oe(pe), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_en(pad_pull_en), .dbg_ack_pulldown_en(dbg));
	always #20 hclk = ~hclk;
	// Xorshift source of stimulus.
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected {oe, out} of all pads from the selects and sources.
	function logic [63:0] pads();
		logic [31:0] r;
		logic [2:0] c;
		logic [63:0] e;
		for (int i = 0; i < 32; i++) begin
			r = i < 6 ? p0 : (i < 23 ? p1 : p2);
			c = i > 22 ? 3'((r >> (2 * i - 46)) & 3) : 3'((r >> lt[i]) & ((1 << wt[i]) - 1));
			e[i] = fs[i] ? po[8 * i + c] : go[i];
			e[32 + i] = fs[i] ? pe[8 * i + c] : ge[i];
		end
		return e;
	endfunction
	// One single AHB transfer; read data is taken at the data-phase edge.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(0, a, 0);
		`CHK($sformatf("reg %h", a), e, rd)
	endtask
	// Select registers take a write only right after the key.
	task psel(input logic [7:0] a, input logic [31:0] d);
		xfer(1, `PFS_OFS_WMASK, ~`PFS_UNLOCK_KEY);
		xfer(1, a, d);
	endtask
	task conclude;
		if (failures == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		conclude;
	end
	// Defaults, refused writes, random routing, pull control, freeze, reset in mid-run.
	initial begin
		go = rnd();
		ge = rnd();
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(negedge hclk);
		`CHK("pads", {ge, go}, {pad_oe, pad_out})
		`CHK("pull", PON & PHC, pad_pull_en)
		`CHK("pulldown", 1'b1, dbg)
		@(posedge hclk);
		for (int a = 0; a < 16; a += 4) rdc(8'(a), 0);
		rdc(`PFS_OFS_PULL, PON & PHC);
		rdc(`PFS_OFS_STRAP, 32'h80000029);
		rdc(8'h40, 0);
		xfer(1, `PFS_OFS_PSEL1, 32'hFFFFFFFF);
		rdc(`PFS_OFS_PSEL1, 0);
		rdc(`PFS_OFS_STATUS, 1);
		xfer(1, `PFS_OFS_STATUS, 1);
		xfer(1, `PFS_OFS_WMASK, ~`PFS_UNLOCK_KEY);
		xfer(1, `PFS_OFS_FUNC_SEL, 0);
		xfer(1, `PFS_OFS_PSEL2, 32'hFFFFFFFF);
		rdc(`PFS_OFS_PSEL2, 0);
		for (int n = 0; n < 40; n++) begin
			fs = n < 2 ? {32{n[0]}} : rnd();
			p0 = n < 2 ? {32{n[0]}} : rnd();
			p1 = n < 2 ? {32{n[0]}} : rnd();
			p2 = n < 2 ? {32{n[0]}} : rnd();
			go <= rnd();
			ge <= rnd();
			po <= {po[223:0], rnd()};
			pe <= {pe[223:0], rnd()};
			psel(`PFS_OFS_PSEL0, p0);
			psel(`PFS_OFS_PSEL1, p1);
			psel(`PFS_OFS_PSEL2, p2);
			xfer(1, `PFS_OFS_FUNC_SEL, fs);
			rdc(`PFS_OFS_PSEL1, p1);
			@(negedge hclk);
			`CHK("route", pads(), {pad_oe, pad_out})
			@(posedge hclk);
		end
		p0 = rnd();
		xfer(1, `PFS_OFS_PULL, p0);
		xfer(1, `PFS_OFS_STRAP, 0);
		@(negedge hclk);
		`CHK("pull", p0 & PHC, pad_pull_en)
		`CHK("pulldown", 1'b0, dbg)
		@(posedge hclk);
		rdc(`PFS_OFS_PULL, p0 & PHC);
		// A write while the clock enable is low must leave the select word alone.
		ce <= 0;
		xfer(1, `PFS_OFS_FUNC_SEL, ~fs);
		ce <= 1;
		rdc(`PFS_OFS_FUNC_SEL, fs);
		hresetn <= 0;
		@(posedge hclk);
		hresetn <= 1;
		@(negedge hclk);
		`CHK("pads", {ge, go}, {pad_oe, pad_out})
		`CHK("pull", PON & PHC, pad_pull_en)
		`CHK("pulldown", 1'b1, dbg)
		@(posedge hclk);
		rdc(`PFS_OFS_FUNC_SEL, 0);
		conclude;
	end
endmodule // testbench
`default_nettype wire
